/* File: pkg/canirq_regs.vh */
// register offsets, field positions and reset values of the can pending and identifier block
`ifndef CANIRQ_REGS_VH
`define CANIRQ_REGS_VH

// =============================================================
// register map (byte addresses, one aligned 32-bit word each)
`define CANIRQ_OFS_PEND1    12'h000
`define CANIRQ_OFS_CLR1     12'h004
`define CANIRQ_OFS_IEN1     12'h008
`define CANIRQ_OFS_PEND2    12'h010
`define CANIRQ_OFS_CLR2     12'h014
`define CANIRQ_OFS_IEN2     12'h018
`define CANIRQ_OFS_MASK     12'h020
`define CANIRQ_OFS_IDBASE   12'h800
`define CANIRQ_ID_STRIDE_SH 3
`define CANIRQ_ID_HIGH_OFS  3'h4

// =============================================================
// fields and reset values
`define CANIRQ_NSRC         7
`define CANIRQ_FMT_BIT      15
`define CANIRQ_PEND_RST     7'h00
`define CANIRQ_IEN_RST      7'h00
`define CANIRQ_MASK_RST     14'h0000
`define CANIRQ_NBUF         32

`endif

/* File: core/canirq_id_mem.v */
// identifier storage for 32 message buffers, low and high halfwords
`timescale 1ns/10ps
module canirq_id_mem (
    // clock
    input  wire        mclk,
    // access
    input  wire        wrEn,
    input  wire [5:0]  addr,
    input  wire [15:0] wrData,
    output reg  [15:0] rdData
);
    reg [15:0] store [0:63];

    // write port and registered read port, 16-bit units
    always @(posedge mclk) begin
        if (wrEn) begin
            store[addr] <= wrData;
        end
        rdData <= store[addr];
    end
endmodule

/* File: core/canirq_top.v */
// interrupt pending logic and message identifier registers behind apb
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "canirq_regs.vh"
module canirq_top (
    // clock and reset
    input  wire        mclk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // interrupt events, bit n is source n, one per channel
    input  wire [6:0]  evtChan1,
    input  wire [6:0]  evtChan2,
    // per-channel interrupt outputs and the combined interrupt
    output wire        irqChan1,
    output wire        irqChan2,
    output wire        irq
);
    // =============================================================
    // bus decode
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable;
    wire        isId     = (paddr[11] == 1'b1);
    wire [5:0]  idAddr   = {paddr[7:3], paddr[2]};
    wire        wrAcc    = access & pwrite & pready;
    wire        hitClr1  = wrAcc & (paddr == `CANIRQ_OFS_CLR1);
    wire        hitClr2  = wrAcc & (paddr == `CANIRQ_OFS_CLR2);
    wire        hitIen1  = wrAcc & (paddr == `CANIRQ_OFS_IEN1);
    wire        hitIen2  = wrAcc & (paddr == `CANIRQ_OFS_IEN2);
    wire        hitMask  = wrAcc & (paddr == `CANIRQ_OFS_MASK);
    wire        idInRange = isId & (paddr[10:8] == 3'h0) & (paddr[1:0] == 2'h0);
    wire        idWr     = wrAcc & idInRange;
    wire [15:0] idRd;
    reg         waitDone;

    // identifier reads get the registered memory output from the setup cycle, so waitDone raises pready in the first access cycle
    always @(posedge mclk) begin
        if (rst) begin
            waitDone <= 1'b0;
        end else begin
            waitDone <= setup & isId;
        end
    end

    assign pready  = ~isId | waitDone | ~access;
    assign pslverr = 1'b0;

    // =============================================================
    // pending, enable and mask registers
    reg [6:0]  pend1;
    reg [6:0]  pend2;
    reg [6:0]  ien1;
    reg [6:0]  ien2;
    reg [13:0] mask;
    reg [6:0]  evtPrev1;
    reg [6:0]  evtPrev2;
    wire [6:0] srcGate = 7'h7E;

    // an event is gated by its enable; source 0 has no enable bit
    wire [6:0] raise1 = evtChan1 & ~evtPrev1 & (ien1 | ~srcGate);
    wire [6:0] raise2 = evtChan2 & ~evtPrev2 & (ien2 | ~srcGate);
    wire [6:0] clr1   = hitClr1 ? pwdata[6:0] : 7'h00;
    wire [6:0] clr2   = hitClr2 ? pwdata[6:0] : 7'h00;

    // sticky pending bits; set wins over clear
    always @(posedge mclk) begin
        if (rst) begin
            pend1    <= `CANIRQ_PEND_RST;
            pend2    <= `CANIRQ_PEND_RST;
            ien1     <= `CANIRQ_IEN_RST;
            ien2     <= `CANIRQ_IEN_RST;
            mask     <= `CANIRQ_MASK_RST;
            evtPrev1 <= 7'h00;
            evtPrev2 <= 7'h00;
        end else begin
            evtPrev1 <= evtChan1;
            evtPrev2 <= evtChan2;
            pend1    <= (pend1 & ~clr1) | raise1;
            pend2    <= (pend2 & ~clr2) | raise2;
            if (hitIen1) begin
                ien1 <= pwdata[6:0];
            end
            if (hitIen2) begin
                ien2 <= pwdata[6:0];
            end
            if (hitMask) begin
                mask <= pwdata[13:0];
            end
        end
    end

    // =============================================================
    // interrupt pulse: one per cycle in which any unmasked pending bit newly sets, none while it stays set
    reg irqPulse1;
    reg irqPulse2;

    always @(posedge mclk) begin
        if (rst) begin
            irqPulse1 <= 1'b0;
            irqPulse2 <= 1'b0;
        end else begin
            irqPulse1 <= |(raise1 & ~pend1 & mask[6:0]);
            irqPulse2 <= |(raise2 & ~pend2 & mask[13:7]);
        end
    end

    assign irqChan1 = irqPulse1;
    assign irqChan2 = irqPulse2;
    assign irq      = |({pend2, pend1} & mask);

    // =============================================================
    // identifier storage
    canirq_id_mem uIdMem (
        .mclk   (mclk),
        .wrEn   (idWr),
        .addr   (idAddr),
        .wrData (pwdata[15:0]),
        .rdData (idRd)
    );

    // =============================================================
    // read mux, unmapped addresses read zero
    always @* begin
        prdata = 32'h00000000;
        if (idInRange) begin
            prdata = {16'h0000, idRd};
        end else if (paddr == `CANIRQ_OFS_PEND1) begin
            prdata = {25'h0000000, pend1};
        end else if (paddr == `CANIRQ_OFS_PEND2) begin
            prdata = {25'h0000000, pend2};
        end else if (paddr == `CANIRQ_OFS_IEN1) begin
            prdata = {25'h0000000, ien1};
        end else if (paddr == `CANIRQ_OFS_IEN2) begin
            prdata = {25'h0000000, ien2};
        end else if (paddr == `CANIRQ_OFS_MASK) begin
            prdata = {18'h00000, mask};
        end
    end
endmodule

/* File: tb/canirq_chk.sv */
// assertions for the can pending and identifier block
`timescale 1ns/10ps
`include "canirq_regs.vh"
module canirq_chk (
    // apb, events and interrupts
    input wire        mclk, rst, psel, penable, pwrite, pready, pslverr,
    input wire        irqChan1, irqChan2, irq,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [6:0]  evtChan1, evtChan2
);
default clocking @(posedge mclk); endclocking
default disable iff (rst);
wire acc = psel && penable;
property p_ctl; acc && !paddr[11] |-> pready; endproperty
a_ctl: assert property (p_ctl) else $error("control stall");
property p_idw; psel && !penable && paddr[11] |=> pready; endproperty
a_idw: assert property (p_idw) else $error("id wait");
property p_clr; acc && !pwrite && paddr == `CANIRQ_OFS_CLR1 |-> prdata == 0; endproperty
a_clr: assert property (p_clr) else $error("clear read");
property p_one1; irqChan1 |=> !irqChan1; endproperty
a_one1: assert property (p_one1) else $error("pulse one");
property p_one2; irqChan2 |=> !irqChan2; endproperty
a_one2: assert property (p_one2) else $error("pulse two");
property p_lvl; irqChan1 || irqChan2 |-> irq; endproperty
a_lvl: assert property (p_lvl) else $error("irq level");
property p_hi; acc && pready && !pwrite && paddr[11] |-> prdata[31:16] == 0; endproperty
a_hi: assert property (p_hi) else $error("id upper");
property p_rst; $past(rst) |-> !irq && !irqChan1 && !irqChan2; endproperty
a_rst: assert property (p_rst) else $error("reset irq");
c_p: cover property (irqChan1);
c_w: cover property (acc && pready && paddr[11]);
c_i: cover property (irq && !irqChan1);
endmodule
bind canirq_top canirq_chk chk_u(.mclk(mclk),.rst(rst),.psel(psel),.penable(penable),
 .pwrite(pwrite),.pready(pready),.pslverr(pslverr),.irqChan1(irqChan1),.irq(irq),
 .irqChan2(irqChan2),.paddr(paddr),.pwdata(pwdata),.prdata(prdata),
 .evtChan1(evtChan1),.evtChan2(evtChan2));

/* File: tb/testbench.sv */
// random and directed stimulus for the can pending and identifier block
`timescale 1ns/10ps
`include "canirq_regs.vh"
module testbench;
reg mclk=0, rst=1, psel=0, penable=0, pwrite=0;
reg [11:0] paddr=0;
reg [31:0] pwdata=0, rd;
reg [6:0] evtChan1=0, evtChan2=0, e1=0, b, c;
reg [15:0] lf=16'hF02E, m, idm[64];
wire [31:0] prdata;
wire pready, pslverr, irqChan1, irqChan2, irq;
int fails=0, samples_checked=0, pc=0, pc2=0, p0, q0, k;
// clock and pulse counters
always #2.5 mclk = ~mclk;
always @(posedge mclk) pc <= pc + irqChan1;
always @(posedge mclk) pc2 <= pc2 + irqChan2;
canirq_top dut_u(.mclk(mclk),.rst(rst),.psel(psel),.penable(penable),.pwrite(pwrite),
 .paddr(paddr),.pwdata(pwdata),.prdata(prdata),.pready(pready),.pslverr(pslverr),
 .evtChan1(evtChan1),.evtChan2(evtChan2),.irqChan1(irqChan1),.irqChan2(irqChan2),.irq(irq));
function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15]^v[13]^v[12]^v[10]};
endfunction
task results;
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task chk(input [31:0] s, e);
    samples_checked++;
    if (s !== e) begin fails++; $display("Error %0t: got %h want %h", $time, s, e); end
endtask
// one apb transfer, bounded wait for pready
task apb(input w, input [11:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge mclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk); penable <= 1;
    // settled values before the edge at which the transfer completes
    @(negedge mclk);
    while (!pready) begin if (++n > 20) begin fails++; results; end @(negedge mclk); end
    rd = prdata;
    chk(pslverr, 0);
    @(posedge mclk); psel <= 0; penable <= 0;
endtask
initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    apb(1, `CANIRQ_OFS_IEN1, 32'h7E);
    apb(1, `CANIRQ_OFS_IEN2, 0);
    // events, masking and clears
    for (k = 0; k < 12; k++) begin
        lf = nx(lf); m = lf; b = lf[6:0]; lf = nx(lf); c = lf[6:0];
        if (k < 2) b = 7'h7F;
        apb(1, `CANIRQ_OFS_MASK, {18'h0, m[13:0]});
        p0 = pc;
        q0 = pc2;
        @(posedge mclk); evtChan1 <= b; evtChan2 <= b;
        @(posedge mclk); evtChan1 <= 0; evtChan2 <= 0;
        apb(0, `CANIRQ_OFS_PEND2, 0); chk(rd, {31'h0, b[0]});
        chk(pc - p0, |(b & ~e1 & m[6:0]));
        chk(pc2 - q0, b[0] & m[7]);
        e1 = e1 | b;
        apb(0, `CANIRQ_OFS_PEND1, 0); chk(rd, {25'h0, e1});
        apb(1, `CANIRQ_OFS_CLR2, 32'h7F);
        apb(1, `CANIRQ_OFS_CLR1, {25'h0, c}); e1 = e1 & ~c;
        apb(0, `CANIRQ_OFS_CLR1, 0); chk(rd, 0);
        apb(0, `CANIRQ_OFS_PEND1, 0); chk(rd, {25'h0, e1});
        chk(irq, |(e1 & m[6:0]));
    end
    // identifier words of all buffers, upper bits dropped
    for (k = 0; k < 64; k++) begin lf = nx(lf); idm[k] = lf; apb(1, 12'h800 + k*4, {~lf, lf}); end
    for (k = 0; k < 64; k++) begin apb(0, 12'h800 + k*4, 0); chk(rd, {16'h0, idm[k]}); end
    apb(1, 12'h030, 32'h1); apb(0, 12'h030, 0); chk(rd, 0);
    results;
end
endmodule
